// >>> hw/rtcsi_core.sv
// rtcsi core: clock/calendar counters, status flags and alarm/clock pin control
`default_nettype none
// How it works
// R1: time fields held in bcd, fixed ranges
// R2: weekday three bits, counts 0..6, wraps
// R3: hour format bit picks 24 or 12h
// R4: february 29 when year divisible by four
// R5: busy flag blocks trim register access
// R6: oscillator stop raises sticky flag
// R7: forward event sets, reverse clears summer flag
// R8: host may set summer flag; enables early
// R9: summer flag cleared at reset, when disabled
// R10: alarm match sets flag; writes only clear
// R11: match during status read survives auto clear
// R12: main supply low flag, trip select register
// R13: two battery low flags, own selects
// R14: power loss flag set at power-up
// R15: first time write clears power loss
// R16: auto clear after status read and stop
// R17: time writes need write enable; stop restarts
// R18: one second tick restarts at stop
// R19: pulse or level alarm on pin
// R20: pulse select means recurring events
// R21: pin released on battery when selected
// R22: four-bit code selects output frequency
// R23: bcd counters carry into next field
module rtcsi_core
	import rtcsi_pkg::*;
#(
	parameter int PULSE_CYCLES = ALARM_PULSE_CYCLES
)(
	input wire logic clock,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic bus_stop,
	output logic [7:0] rd_data,
	input wire logic osc_clock_level,
	input wire logic osc_running,
	input wire logic temp_busy,
	input wire logic on_battery,
	input wire logic main_supply_below,
	input wire logic battery_below_first,
	input wire logic battery_below_second,
	input wire logic alarm_match,
	input wire logic summer_fwd_event,
	input wire logic summer_rev_event,
	input wire logic summer_time_enable,
	output logic [2:0] main_trip_select,
	output logic [2:0] battery_trip_first,
	output logic [2:0] battery_trip_second,
	output logic alarm_clock_pin_o,
	output logic alarm_clock_pin_oe
);
	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------
	// bcd increment of one byte
	function automatic logic [7:0] bcd_next(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		if (v[3:0] == 4'h9)
			r = {v[7:4] + 4'h1, 4'h0};
		else
			r = {v[7:4], v[3:0] + 4'h1};
		return r;
	endfunction
	// leap test on two bcd digits, no century exception
	function automatic logic is_leap(input logic [7:0] y);
		logic odd;
		odd = y[4];
		return odd ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
	endfunction
	// last date of a month
	function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
		logic [7:0] d;
		d = 8'h31;
		case (m)
			8'h02: d = is_leap(y) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: d = 8'h30;
			default: d = 8'h31;
		endcase
		return d;
	endfunction
	// hour step, top bit is the day carry
	function automatic logic [8:0] hour_step(input logic [7:0] h);
		logic [8:0] r;
		logic [7:0] low;
		logic [7:0] inc24; // next hour, 24 hour form
		logic [7:0] inc12; // next hour, 12 hour form
		r = {1'b0, h};
		low = {3'b000, h[4:0]};
		inc24 = bcd_next({2'b00, h[5:0]});
		inc12 = bcd_next(low);
		if (h[HOUR_FORMAT_BIT])
		begin
			// 24 hour form
			if (h[5:0] == 6'h23)
				r = {1'b1, 8'h80};
			else
				r = {1'b0, 2'b10, inc24[5:0]};
		end
		else if (low == 8'h12)
			r = {1'b0, 2'b00, h[PM_BIT], 5'h01};
		else if (low == 8'h11)
			r = {h[PM_BIT], 2'b00, ~h[PM_BIT], 5'h12};
		else
			r = {1'b0, 2'b00, h[PM_BIT], inc12[4:0]};
		return r;
	endfunction
	// prescaler tap for a frequency code
	function automatic logic [4:0] freq_tap(input logic [3:0] code);
		logic [4:0] t;
		t = {1'b0, code} + 5'h04;
		if (code == 4'h2)
			t = 5'h02;
		else if (code == 4'h3)
			t = 5'h04;
		return t;
	endfunction
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] seconds_counter_ff; // bcd seconds
	logic [7:0] minutes_counter_ff; // bcd minutes
	logic [7:0] hours_counter_ff; // format bit, pm, bcd hours
	logic [7:0] day_of_month_counter_ff; // bcd date
	logic [7:0] calendar_period_counter_ff; // bcd month
	logic [7:0] annual_counter_ff; // bcd year
	logic [2:0] weekday_counter_ff; // weekday
	rtcsi_status_s status_byte_ff; // status flags
	logic [7:0] control_ff; // control register
	logic [2:0] main_trip_ff; // main trip select
	logic [5:0] bat_trip_ff; // battery trip selects
	logic [7:0] rd_data_ff; // read data
	logic osc_prev_ff; // oscillator level last cycle
	logic [PRESCALE_W-1:0] prescale_ff; // oscillator divider
	logic hold_ff; // time write pending
	logic read_pending_ff; // status read pending
	logic [3:0] read_snap_ff; // flags seen by the read
	logic [PULSE_W-1:0] pulse_cnt_ff; // alarm pulse length
	logic pin_oe_ff; // pin pull-down
	logic osc_rise; // oscillator edge
	logic sec_tick; // one second
	logic time_write; // accepted time write
	logic status_write; // status write
	logic stop_clear; // auto clear moment
	logic freq_level; // output wave
	rtcsi_pin_mode_e pin_mode; // pin source
	logic nxt_pin_oe; // next pin state
	logic [8:0] hour_nxt; // hour step result
	logic [3:0] flag_set; // alarm, main, bat1, bat2 sets
	logic [3:0] flag_now; // current values of those
	logic [3:0] flag_clr; // clears of those

	assign osc_rise = osc_clock_level & ~osc_prev_ff;
	assign sec_tick = osc_rise & ~hold_ff & (prescale_ff[14:0] == SECOND_WRAP);
	assign time_write = reg_write & control_ff[CTL_WRITE_EN] & (reg_addr <= REG_WEEKDAY); // [R17]
	assign status_write = reg_write & (reg_addr == REG_STATUS);
	assign stop_clear = bus_stop & read_pending_ff & control_ff[CTL_AUTO_CLEAR];
	assign hour_nxt = hour_step(hours_counter_ff);
	assign flag_set = {alarm_match, main_supply_below, battery_below_first, battery_below_second};
	assign flag_now = {status_byte_ff.alarm, status_byte_ff.main_low,
		status_byte_ff.bat_first, status_byte_ff.bat_second};
	assign rd_data = rd_data_ff;
	assign main_trip_select = main_trip_ff;
	assign battery_trip_first = bat_trip_ff[5:3];
	assign battery_trip_second = bat_trip_ff[2:0];
	assign alarm_clock_pin_o = 1'b0;
	assign alarm_clock_pin_oe = pin_oe_ff;

	// ----------------------------------------------------------------
	// oscillator divider and write hold
	// ----------------------------------------------------------------
	// divider counts oscillator edges, frozen during a time write
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			osc_prev_ff <= 1'b0;
			prescale_ff <= '0;
			hold_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			osc_prev_ff <= osc_clock_level;
			if (time_write)
				hold_ff <= 1'b1; // [R17]
			else if (bus_stop && hold_ff)
			begin
				hold_ff <= 1'b0; // [R17]
				prescale_ff <= '0; // [R18]
			end
			else if (osc_rise && !hold_ff)
				prescale_ff <= prescale_ff + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// time and calendar
	// ----------------------------------------------------------------
	// write wins over the tick; tick carries through the fields
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			seconds_counter_ff <= SECONDS_RESET;
			minutes_counter_ff <= SECONDS_RESET;
			hours_counter_ff <= HOURS_RESET; // [R3]
			day_of_month_counter_ff <= DATE_RESET;
			calendar_period_counter_ff <= DATE_RESET;
			annual_counter_ff <= YEAR_RESET;
			weekday_counter_ff <= WEEKDAY_RESET; // [R2]
		end
		else if (clk_en)
		begin
			if (time_write)
			begin
				// bcd fields masked to their widths
				case (reg_addr)
					REG_SECONDS: seconds_counter_ff <= reg_wdata & 8'h7f; // [R1]
					REG_MINUTES: minutes_counter_ff <= reg_wdata & 8'h7f;
					REG_HOURS: hours_counter_ff <= reg_wdata & 8'hbf; // [R3]
					REG_DATE: day_of_month_counter_ff <= reg_wdata & 8'h3f;
					REG_MONTH: calendar_period_counter_ff <= reg_wdata & 8'h1f;
					REG_YEAR: annual_counter_ff <= reg_wdata;
					default: weekday_counter_ff <= reg_wdata[2:0];
				endcase
			end
			else if (sec_tick)
			begin
				seconds_counter_ff <= bcd_next(seconds_counter_ff); // [R1]
				if (seconds_counter_ff == 8'h59)
				begin
					seconds_counter_ff <= 8'h00; // [R23]
					minutes_counter_ff <= bcd_next(minutes_counter_ff);
					if (minutes_counter_ff == 8'h59)
					begin
						minutes_counter_ff <= 8'h00;
						hours_counter_ff <= hour_nxt[7:0]; // [R3]
						if (hour_nxt[8])
						begin
							// new day
							weekday_counter_ff <= (weekday_counter_ff == 3'h6) ? 3'h0
								: weekday_counter_ff + 3'h1; // [R2]
							day_of_month_counter_ff <= bcd_next(day_of_month_counter_ff);
							if (day_of_month_counter_ff == month_last(calendar_period_counter_ff,
								annual_counter_ff)) // [R4]
							begin
								day_of_month_counter_ff <= 8'h01; // [R23]
								calendar_period_counter_ff <= bcd_next(calendar_period_counter_ff);
								if (calendar_period_counter_ff == 8'h12)
								begin
									calendar_period_counter_ff <= 8'h01;
									annual_counter_ff <= (annual_counter_ff == 8'h99) ? 8'h00
										: bcd_next(annual_counter_ff); // [R1]
								end
							end
						end
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	// clears from a status write or an auto clear at stop
	always_comb
	begin
		flag_clr = 4'h0;
		if (status_write)
			flag_clr = ~{reg_wdata[4], reg_wdata[3], reg_wdata[2], reg_wdata[1]}; // [R10]
		if (stop_clear)
			flag_clr = flag_clr | read_snap_ff; // [R16]
	end

	// set wins over every clear, except the summer flag, where a reverse event or disable beats a forward event
	always_ff @(posedge clock)
	begin
		if (reset)
			status_byte_ff <= STATUS_RESET; // [R14] [R9]
		else if (clk_en)
		begin
			status_byte_ff.busy <= temp_busy; // [R5]
			status_byte_ff.osc_stop <= ~osc_running
				| (status_byte_ff.osc_stop & ~(status_write & ~reg_wdata[6])); // [R6]
			{status_byte_ff.alarm, status_byte_ff.main_low, status_byte_ff.bat_first,
				status_byte_ff.bat_second} <= (flag_now & ~flag_clr) | flag_set; // [R12] [R13]
			if (!summer_time_enable || summer_rev_event)
				status_byte_ff.summer_applied <= 1'b0; // [R7] [R9]
			else if (summer_fwd_event)
				status_byte_ff.summer_applied <= 1'b1; // [R7]
			else if (status_write)
				status_byte_ff.summer_applied <= reg_wdata[ST_SUMMER]; // [R8]
			if (time_write)
				status_byte_ff.power_loss <= 1'b0; // [R15]
		end
	end

	// snapshot of flags read; a new set during the read protects its bit
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			read_pending_ff <= 1'b0;
			read_snap_ff <= 4'h0;
		end
		else if (clk_en)
		begin
			if (bus_stop)
			begin
				read_pending_ff <= 1'b0;
				read_snap_ff <= 4'h0;
			end
			else if (reg_read && reg_addr == REG_STATUS)
			begin
				read_pending_ff <= 1'b1;
				read_snap_ff <= flag_now & ~flag_set;
			end
			else
				read_snap_ff <= read_snap_ff & ~flag_set; // [R11]
		end
	end

	// ----------------------------------------------------------------
	// control and trip registers
	// ----------------------------------------------------------------
	// plain storage, trip selects drive the monitors
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			control_ff <= CONTROL_RESET; // [R22]
			main_trip_ff <= TRIP_RESET[2:0];
			bat_trip_ff <= TRIP_RESET[5:0];
		end
		else if (clk_en && reg_write)
		begin
			if (reg_addr == REG_CONTROL)
				control_ff <= reg_wdata;
			else if (reg_addr == REG_MAIN_TRIP)
				main_trip_ff <= reg_wdata[2:0]; // [R12]
			else if (reg_addr == REG_BAT_TRIP)
				bat_trip_ff <= reg_wdata[5:0]; // [R13]
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// data registered on the read strobe
	always_ff @(posedge clock)
	begin
		if (reset)
			rd_data_ff <= 8'h00;
		else if (clk_en && reg_read)
		begin
			case (reg_addr)
				REG_SECONDS: rd_data_ff <= seconds_counter_ff;
				REG_MINUTES: rd_data_ff <= minutes_counter_ff;
				REG_HOURS: rd_data_ff <= hours_counter_ff;
				REG_DATE: rd_data_ff <= day_of_month_counter_ff;
				REG_MONTH: rd_data_ff <= calendar_period_counter_ff;
				REG_YEAR: rd_data_ff <= annual_counter_ff;
				REG_WEEKDAY: rd_data_ff <= {5'h00, weekday_counter_ff};
				REG_STATUS: rd_data_ff <= status_byte_ff;
				REG_CONTROL: rd_data_ff <= control_ff;
				REG_MAIN_TRIP: rd_data_ff <= {5'h00, main_trip_ff};
				REG_BAT_TRIP: rd_data_ff <= {2'b00, bat_trip_ff};
				REG_TRIM: rd_data_ff <= status_byte_ff.busy ? 8'h00 : TRIM_PRESET; // [R5]
				default: rd_data_ff <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// alarm / clock pin
	// ----------------------------------------------------------------
	// each match restarts the pulse in pulse mode
	always_ff @(posedge clock)
	begin
		if (reset)
			pulse_cnt_ff <= '0;
		else if (clk_en)
		begin
			if (alarm_match && control_ff[CTL_PULSE_SEL])
				pulse_cnt_ff <= PULSE_W'(PULSE_CYCLES); // [R19] [R20]
			else if (pulse_cnt_ff != '0)
				pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
		end
	end

	// pick the pin source; frequency overrides the alarm
	always_comb
	begin
		freq_level = (control_ff[3:0] == 4'h1) ? osc_clock_level
			: prescale_ff[freq_tap(control_ff[3:0])]; // [R22]
		if (control_ff[CTL_PIN_OFF] && on_battery)
			pin_mode = PIN_RELEASED; // [R21]
		else if (control_ff[3:0] != 4'h0)
			pin_mode = PIN_FREQ;
		else if (control_ff[CTL_PULSE_SEL])
			pin_mode = PIN_PULSE;
		else
			pin_mode = PIN_LEVEL;
		case (pin_mode)
			PIN_FREQ: nxt_pin_oe = ~freq_level; // [R22]
			PIN_PULSE: nxt_pin_oe = (pulse_cnt_ff != '0); // [R19]
			PIN_LEVEL: nxt_pin_oe = status_byte_ff.alarm; // [R19]
			default: nxt_pin_oe = 1'b0;
		endcase
	end

	// registered pull-down
	always_ff @(posedge clock)
	begin
		if (reset)
			pin_oe_ff <= 1'b0;
		else if (clk_en)
			pin_oe_ff <= nxt_pin_oe;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_weekday_range: assert property (@(posedge clock) disable iff (reset) // [R2]
		weekday_counter_ff <= 3'h6) else $error("weekday out of range");
	a_seconds_range: assert property (@(posedge clock) disable iff (reset) // [R1]
		seconds_counter_ff[7:4] <= 4'h5 && seconds_counter_ff[3:0] <= 4'h9)
		else $error("seconds out of range");
	a_trim_blocked: assert property (@(posedge clock) disable iff (reset) // [R5]
		clk_en && reg_read && reg_addr == REG_TRIM && status_byte_ff.busy |=> rd_data_ff == 8'h00)
		else $error("trim readable while busy");
	a_osc_flag: assert property (@(posedge clock) disable iff (reset) // [R6]
		clk_en && !osc_running |=> status_byte_ff.osc_stop) else $error("osc stop missed");
	a_summer_off: assert property (@(posedge clock) disable iff (reset) // [R9]
		clk_en && !summer_time_enable |=> !status_byte_ff.summer_applied)
		else $error("summer flag kept while disabled");
	a_alarm_noset: assert property (@(posedge clock) disable iff (reset) // [R10]
		clk_en && status_write && !status_byte_ff.alarm && !alarm_match |=> !status_byte_ff.alarm)
		else $error("write set alarm flag");
	a_loss_clear: assert property (@(posedge clock) disable iff (reset) // [R15]
		clk_en && time_write |=> !status_byte_ff.power_loss) else $error("power loss not cleared");
	a_tick_restart: assert property (@(posedge clock) disable iff (reset) // [R18]
		clk_en && bus_stop && hold_ff && !time_write |=> prescale_ff == '0 && !hold_ff)
		else $error("tick not restarted");
	a_backup_off: assert property (@(posedge clock) disable iff (reset) // [R21]
		clk_en && on_battery && control_ff[CTL_PIN_OFF] |=> !pin_oe_ff)
		else $error("pin active on battery");
	a_alarm_level: assert property (@(posedge clock) disable iff (reset) // [R19]
		clk_en && pin_mode == PIN_LEVEL && status_byte_ff.alarm |=> pin_oe_ff)
		else $error("level alarm not driven");
endmodule
`default_nettype wire

// >>> hw/rtcsi_pkg.sv
// rtcsi package: register map, field positions, reset values and shared types
`default_nettype none
package rtcsi_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_SECONDS = 8'h00;
	localparam logic [7:0] REG_MINUTES = 8'h01;
	localparam logic [7:0] REG_HOURS = 8'h02;
	localparam logic [7:0] REG_DATE = 8'h03;
	localparam logic [7:0] REG_MONTH = 8'h04;
	localparam logic [7:0] REG_YEAR = 8'h05;
	localparam logic [7:0] REG_WEEKDAY = 8'h06;
	localparam logic [7:0] REG_STATUS = 8'h07;
	localparam logic [7:0] REG_CONTROL = 8'h08;
	localparam logic [7:0] REG_MAIN_TRIP = 8'h09;
	localparam logic [7:0] REG_BAT_TRIP = 8'h0a;
	localparam logic [7:0] REG_TRIM = 8'h0b;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int HOUR_FORMAT_BIT = 7;
	localparam int PM_BIT = 5;
	localparam int CTL_AUTO_CLEAR = 7;
	localparam int CTL_WRITE_EN = 6;
	localparam int CTL_PULSE_SEL = 5;
	localparam int CTL_PIN_OFF = 4;
	localparam int ST_SUMMER = 5;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] STATUS_RESET = 8'h01;
	localparam logic [7:0] CONTROL_RESET = 8'h01;
	localparam logic [7:0] TRIP_RESET = 8'h00;
	localparam logic [7:0] TRIM_PRESET = 8'h5a; // arbitrary preset trim value
	localparam logic [7:0] SECONDS_RESET = 8'h00;
	localparam logic [7:0] HOURS_RESET = 8'h12;
	localparam logic [7:0] DATE_RESET = 8'h01;
	localparam logic [7:0] YEAR_RESET = 8'h00;
	localparam logic [2:0] WEEKDAY_RESET = 3'h0;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLOCK_HZ = 50_000_000;
	localparam int ALARM_PULSE_MS = 250;
	localparam int ALARM_PULSE_CYCLES = ALARM_PULSE_MS * (CLOCK_HZ / 1000);
	localparam int PULSE_W = 24;
	localparam int PRESCALE_W = 20;
	localparam logic [14:0] SECOND_WRAP = 15'h7fff;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic busy;
		logic osc_stop;
		logic summer_applied;
		logic alarm;
		logic main_low;
		logic bat_first;
		logic bat_second;
		logic power_loss;
	} rtcsi_status_s;
	typedef enum logic [1:0] {PIN_RELEASED, PIN_FREQ, PIN_PULSE, PIN_LEVEL} rtcsi_pin_mode_e;
endpackage
`default_nettype wire

// >>> sim/rtcsi_osc_model.sv
// rtcsi oscillator model: fast crystal level and running status
`default_nettype none
module rtcsi_osc_model
	import rtcsi_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic halt,
	output logic osc_clock_level,
	output logic osc_running
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// level toggles each cycle, so a second is 65536 cycles
	// ----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (reset || halt)
			osc_clock_level <= 1'b0; // stands still while halted
		else
			osc_clock_level <= ~osc_clock_level;
	end
	assign osc_running = ~halt;
endmodule
`default_nettype wire

// >>> sim/tb_rtcsi_core.sv
// rtcsi testbench: register accesses, calendar rollover, flags and pin checks
`default_nettype none
module tb_rtcsi_core
	import rtcsi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic write = 1'b0;
	logic read = 1'b0;
	logic stop = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [2:0] ev = 3'h0; // alarm, forward, reverse pulses
	logic mlow = 1'b0;
	logic b1 = 1'b0;
	logic b2 = 1'b0;
	logic pin_o;
	logic busy = 1'b0;
	logic batt = 1'b0;
	logic sen = 1'b0;
	logic halt = 1'b0;
	wire osc_lvl;
	wire osc_run;
	logic [7:0] rd_data;
	logic [2:0] trip_m;
	logic [2:0] trip_1;
	logic [2:0] trip_2;
	logic pin_oe;
	int error_cnt = 0;
	int n_tests = 0;
	localparam logic [7:0] TV [7] = '{8'h59, 8'h59, 8'h31, 8'h28, 8'h02, 8'h04, 8'h06};
	localparam logic [7:0] EX [7] = '{8'h00, 8'h00, 8'h12, 8'h29, 8'h02, 8'h04, 8'h00};
	always #10 clock = ~clock;
	// ----------------------------------------------------------------
	// design and oscillator model
	// ----------------------------------------------------------------
	rtcsi_core #(.PULSE_CYCLES(20)) i_dut (.clock(clock), .reset(reset), .clk_en(1'b1),
		.reg_addr(addr), .reg_wdata(wdata), .reg_write(write), .reg_read(read),
		.bus_stop(stop), .rd_data(rd_data), .osc_clock_level(osc_lvl),
		.osc_running(osc_run), .temp_busy(busy), .on_battery(batt),
		.main_supply_below(mlow), .battery_below_first(b1),
		.battery_below_second(b2), .alarm_match(ev[0]), .summer_fwd_event(ev[1]),
		.summer_rev_event(ev[2]), .summer_time_enable(sen), .main_trip_select(trip_m),
		.battery_trip_first(trip_1), .battery_trip_second(trip_2),
		.alarm_clock_pin_o(pin_o), .alarm_clock_pin_oe(pin_oe));
	rtcsi_osc_model i_osc (.clock(clock), .reset(reset), .halt(halt),
		.osc_clock_level(osc_lvl), .osc_running(osc_run));
	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic results;
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		addr = a;
		wdata = d;
		write = 1'b1;
		@(negedge clock);
		write = 1'b0;
	endtask
	task automatic rdq(input logic [7:0] a);
		@(negedge clock);
		addr = a;
		read = 1'b1;
		@(negedge clock);
		read = 1'b0;
		@(negedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		rdq(a);
		chk(rd_data, exp);
	endtask
	task automatic pulse(input int i);
		@(negedge clock);
		ev[i] = 1'b1;
		@(negedge clock);
		ev = 3'h0;
	endtask
	// counts pin changes over n cycles, after one cycle to settle
	task automatic edges(input int n, input logic [7:0] exp);
		int c;
		logic p;
		c = 0;
		@(negedge clock);
		p = pin_oe;
		repeat (n)
		begin
			@(negedge clock);
			c += int'(pin_oe != p);
			p = pin_oe;
		end
		chk(8'(c), exp);
	endtask
	task automatic stp;
		@(negedge clock);
		stop = 1'b1;
		@(negedge clock);
		stop = 1'b0;
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (20) @(negedge clock);
		reset = 1'b0;
		rd(REG_STATUS, 8'h01);
		rd(REG_CONTROL, 8'h01);
		edges(64, 8'h40);
		rd(REG_HOURS, 8'h12);
		rd(REG_WEEKDAY, 8'h00);
		wr(REG_SECONDS, 8'h30);
		rd(REG_SECONDS, 8'h00);
		wr(REG_CONTROL, 8'h40);
		for (int i = 0; i < 7; i++)
			wr(8'(i), TV[i]);
		stp();
		repeat (60000) @(negedge clock);
		rd(REG_SECONDS, 8'h59);
		for (int k = 0; k < 3000 && rd_data !== 8'h00; k++)
			rdq(REG_SECONDS);
		if (rd_data !== 8'h00)
		begin
			chk(rd_data, 8'h00);
			results();
		end
		for (int i = 0; i < 7; i++)
			rd(8'(i), EX[i]);
		rd(REG_STATUS, 8'h00);
		wr(REG_CONTROL, 8'h42);
		edges(64, 8'h08);
		wr(REG_CONTROL, 8'h40);
		wr(REG_STATUS, 8'hff);
		rd(REG_STATUS, 8'h00);
		pulse(0);
		rd(REG_STATUS, 8'h10);
		chk(8'(pin_oe), 8'h01);
		chk(8'(pin_o), 8'h00);
		wr(REG_CONTROL, 8'hc0);
		@(negedge clock) mlow = 1'b1;
		@(negedge clock) mlow = 1'b0;
		rd(REG_STATUS, 8'h18);
		pulse(0);
		stp();
		rd(REG_STATUS, 8'h10);
		wr(REG_CONTROL, 8'h50);
		batt = 1'b1;
		repeat (3) @(negedge clock);
		chk(8'(pin_oe), 8'h00);
		batt = 1'b0;
		repeat (3) @(negedge clock);
		chk(8'(pin_oe), 8'h01);
		wr(REG_CONTROL, 8'h60);
		pulse(0);
		@(negedge clock);
		chk(8'(pin_oe), 8'h01);
		repeat (25) @(negedge clock);
		chk(8'(pin_oe), 8'h00);
		sen = 1'b1; // summer handling on before any event
		pulse(1);
		rd(REG_STATUS, 8'h30);
		pulse(2);
		rd(REG_STATUS, 8'h10);
		wr(REG_STATUS, 8'h30);
		rd(REG_STATUS, 8'h30);
		pulse(1);
		sen = 1'b0;
		rd(REG_STATUS, 8'h10);
		wr(REG_MAIN_TRIP, 8'h05);
		wr(REG_BAT_TRIP, 8'h2b);
		@(negedge clock);
		chk({trip_m, trip_1, trip_2[1:0]}, {3'h5, 3'h5, 2'h3});
		chk(8'(trip_2), 8'h03);
		@(negedge clock) b1 = 1'b1;
		@(negedge clock) b1 = 1'b0;
		rd(REG_STATUS, 8'h14);
		@(negedge clock) b2 = 1'b1;
		@(negedge clock) b2 = 1'b0;
		rd(REG_STATUS, 8'h16);
		wr(REG_STATUS, 8'h00);
		rd(REG_STATUS, 8'h00);
		busy = 1'b1;
		rd(REG_STATUS, 8'h80);
		rd(REG_TRIM, 8'h00);
		busy = 1'b0;
		rd(REG_TRIM, TRIM_PRESET);
		halt = 1'b1;
		rd(REG_STATUS, 8'h40);
		rd(8'h20, 8'h00);
		wr(REG_HOURS, 8'ha3);
		rd(REG_HOURS, 8'ha3);
		results();
	end
endmodule
`default_nettype wire
